/* hdl/dmagc_pkg.sv */
// Package of constants and types for the DMA global control block
//
// Summary of operation
// - Debug run bit survives software reset
// - Debugger halt freezes controller unless debug run set
// - Reserved bits read zero; software writes zeros
// - Three 2-bit service fields, reset 0x15
// - Trigger bit write one fires if not pending
// - Trigger bit clears when channel pending sets
// - Pending already set: bit sets, no trigger
// - Writing zero clears trigger bit
// - Level 3/2 enable bits pick static or round-robin
// - Levels 1/0 enable bits 15/7, pointers
// - Round-robin pointer records last granted channel
// - Static pointer x ranks channel x highest
// - Disabling round-robin loads pointer from the written value
package dmagc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DMAGC_CHANNELS = 12;
  localparam int DMAGC_LEVELS = 4;
  localparam int DMAGC_ADDR_W = 8;
  localparam int DMAGC_PTR_W = 4;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] DMAGC_DEBUG_CONTROL = 8'h0d;
  localparam logic [7:0] DMAGC_QOS_CONTROL = 8'h0e;
  localparam logic [7:0] DMAGC_SOFTWARE_TRIGGER_CONTROL = 8'h10;
  localparam logic [7:0] DMAGC_PRIORITY_CONTROL_ZERO = 8'h14;
  // ----------------------------------------
  // Reset values and field layout
  // ----------------------------------------
  localparam logic [5:0] DMAGC_QOS_RESET = 6'h15;
  localparam logic [7:0] DMAGC_DEBUG_MASK = 8'h01;
  localparam logic [7:0] DMAGC_QOS_MASK = 8'h3f;
  localparam logic [31:0] DMAGC_TRIG_MASK = 32'h0000_0fff;
  localparam logic [31:0] DMAGC_PRIO_MASK = 32'h8f8f_8f8f;
  localparam int DMAGC_LEVEL_STRIDE = 8;
  localparam int DMAGC_RR_BIT = 7;
  localparam logic [3:0] DMAGC_LAST_CHANNEL = 4'hb;
  // One bit per channel, used for requests and trigger bits
  typedef logic [DMAGC_CHANNELS-1:0] dmagc_chan_t;
endpackage

/* hdl/dmagc_arb_if.sv */
// Interface between global control and the per-level arbiter
interface dmagc_arb_if;
  import dmagc_pkg::*;
  // Requests of each level
  dmagc_chan_t req [DMAGC_LEVELS];
  // Round-robin enables
  logic [DMAGC_LEVELS-1:0] rr_on;
  // Channel pointers
  logic [DMAGC_PTR_W-1:0] ptr [DMAGC_LEVELS];
  // Grant valid per level
  logic [DMAGC_LEVELS-1:0] gnt_valid;
  // Granted channel per level
  logic [DMAGC_PTR_W-1:0] gnt_chan [DMAGC_LEVELS];
  modport ctrl (output req, output rr_on, output ptr, input gnt_valid, input gnt_chan);
  modport arb (input req, input rr_on, input ptr, output gnt_valid, output gnt_chan);
endinterface

/* hdl/dmagc_arbiter.sv */
// Combinational per-level channel arbiter
module dmagc_arbiter
  import dmagc_pkg::*;
(
  // Arbitration bundle
  dmagc_arb_if.arb arb
);
  // ----------------------------------------
  // Search helpers
  // ----------------------------------------
  // Next channel after a given one, wrapping at the last channel
  function automatic logic [3:0] dmagc_next(input logic [3:0] ch);
    dmagc_next = (ch >= DMAGC_LAST_CHANNEL) ? 4'h0 : 4'(ch + 4'h1);
  endfunction

  // First requester found walking upward from start
  function automatic logic [4:0] dmagc_pick(input dmagc_chan_t req, input logic [3:0] start);
    logic [3:0] ch;
    logic found;
    ch = (start > DMAGC_LAST_CHANNEL) ? 4'h0 : start;
    found = 1'b0;
    dmagc_pick = 5'h00;
    for (int i = 0; i < DMAGC_CHANNELS; i++)
    begin
      if (!found && req[ch])
      begin
        found = 1'b1;
        dmagc_pick = {1'b1, ch};
      end
      ch = dmagc_next(ch);
    end
  endfunction

  // ----------------------------------------
  // One search per level
  // ----------------------------------------
  for (genvar l = 0; l < DMAGC_LEVELS; l++)
  begin : g_lvl
    // Round-robin starts after last grant, static starts at pointer
    wire [3:0] start = arb.rr_on[l] ? dmagc_next(arb.ptr[l]) : arb.ptr[l];
    wire [4:0] pick = dmagc_pick(arb.req[l], start);
    assign arb.gnt_valid[l] = pick[4];
    assign arb.gnt_chan[l] = pick[3:0];
  end
endmodule

/* hdl/dmagc_top.sv */
// Global control registers of the twelve-channel DMA controller
module dmagc_top
  import dmagc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic SOFT_RESET,
  // Register port
  input wire logic [DMAGC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // System status
  input wire logic DEBUG_HALT,
  input wire logic CTRL_ENABLE,
  input wire logic WRITE_PROTECT,
  // Channel side
  input wire logic [DMAGC_CHANNELS-1:0] CHANNEL_PENDING_FLAG,
  input wire logic [DMAGC_CHANNELS-1:0] CHAN_REQUEST,
  input wire logic [2*DMAGC_CHANNELS-1:0] CHAN_LEVEL,
  output logic [DMAGC_CHANNELS-1:0] SOFT_TRIGGER_PULSE,
  output logic [DMAGC_LEVELS-1:0] GRANT_VALID,
  output logic [4*DMAGC_LEVELS-1:0] GRANT_CHANNEL,
  // Controller control
  output logic CONTROLLER_HALT,
  output logic [1:0] DATA_MASTER_SERVICE_LEVEL,
  output logic [1:0] FETCH_MASTER_SERVICE_LEVEL,
  output logic [1:0] WRITEBACK_MASTER_SERVICE_LEVEL
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic halt_meta; // First stage of debug halt
  logic halt_sync; // Debug halt, safe to use
  logic [DMAGC_CHANNELS-1:0] pend_meta; // First stage of pending flags
  logic [DMAGC_CHANNELS-1:0] pend_sync; // Pending flags, safe to use
  logic [DMAGC_CHANNELS-1:0] pend_last; // Synced pending flags one cycle back

  // Two flops on the pins from other logic
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
      pend_meta <= '0;
      pend_sync <= '0;
      pend_last <= '0;
    end
    else if (CE)
    begin
      halt_meta <= DEBUG_HALT;
      halt_sync <= halt_meta;
      pend_meta <= CHANNEL_PENDING_FLAG;
      pend_sync <= pend_meta;
      pend_last <= pend_sync;
    end
  end

  // Pending just became set; a level would wipe a bit set while pending
  wire [DMAGC_CHANNELS-1:0] pend_rise = pend_sync & ~pend_last;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic run_in_debug_halt; // Keep running under debugger
  logic [5:0] qos; // Three service level fields
  dmagc_chan_t channel_soft_trigger; // Software trigger bits
  logic [DMAGC_LEVELS-1:0] rr_on; // Round-robin enable per level
  logic [DMAGC_PTR_W-1:0] ptr [DMAGC_LEVELS]; // Channel pointer per level
  logic frozen; // Controller halted by debugger

  // Controller freeze when debugger halts and debug run clear
  assign frozen = halt_sync && !run_in_debug_halt;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_ok = WR && !WRITE_PROTECT;
  wire wr_dbg = wr_ok && (ADDR == DMAGC_DEBUG_CONTROL);
  wire wr_qos = wr_ok && (ADDR == DMAGC_QOS_CONTROL) && !CTRL_ENABLE;
  wire wr_trig = wr_ok && (ADDR == DMAGC_SOFTWARE_TRIGGER_CONTROL);
  wire wr_prio = wr_ok && (ADDR == DMAGC_PRIORITY_CONTROL_ZERO);
  wire [DMAGC_CHANNELS-1:0] wr_ones = WDATA[DMAGC_CHANNELS-1:0];

  // Trigger fires on a one written to a channel not yet pending
  wire [DMAGC_CHANNELS-1:0] fire = wr_trig ? (wr_ones & ~pend_sync) : '0;

  // Next trigger bits: write loads, pending rise clears, set wins on the write
  dmagc_chan_t next_trigger;
  assign next_trigger = wr_trig ? (wr_ones & pend_sync)
                                : (channel_soft_trigger & ~pend_rise);

  // ----------------------------------------
  // Arbiter
  // ----------------------------------------
  dmagc_arb_if arb_bus ();

  // Requests sorted by each channel's level, gated by freeze
  for (genvar l = 0; l < DMAGC_LEVELS; l++)
  begin : g_req
    for (genvar c = 0; c < DMAGC_CHANNELS; c++)
    begin : g_ch
      assign arb_bus.req[l][c] = CHAN_REQUEST[c] && !frozen
                                 && (CHAN_LEVEL[2*c +: 2] == 2'(l));
    end
    assign arb_bus.ptr[l] = ptr[l];
  end
  assign arb_bus.rr_on = rr_on;

  dmagc_arbiter u_arb (
    .arb (arb_bus)
  );

  // ----------------------------------------
  // Debug run bit: software reset does not touch it
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      run_in_debug_halt <= 1'b0;
    else if (CE && wr_dbg)
      run_in_debug_halt <= WDATA[0];
  end

  // ----------------------------------------
  // Other registers, also returned to reset values by software reset
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      qos <= DMAGC_QOS_RESET;
      channel_soft_trigger <= '0;
      rr_on <= '0;
      for (int l = 0; l < DMAGC_LEVELS; l++)
        ptr[l] <= '0;
    end
    else if (CE)
    begin
      if (SOFT_RESET)
      begin
        qos <= DMAGC_QOS_RESET;
        channel_soft_trigger <= '0;
        rr_on <= '0;
        for (int l = 0; l < DMAGC_LEVELS; l++)
          ptr[l] <= '0;
      end
      else
      begin
        if (wr_qos)
          qos <= WDATA[5:0];
        channel_soft_trigger <= next_trigger;
        for (int l = 0; l < DMAGC_LEVELS; l++)
        begin
          if (wr_prio)
          begin
            // Enable bit and pointer both loaded from the written byte
            rr_on[l] <= WDATA[l*DMAGC_LEVEL_STRIDE + DMAGC_RR_BIT];
            ptr[l] <= WDATA[l*DMAGC_LEVEL_STRIDE +: DMAGC_PTR_W];
          end
          else if (rr_on[l] && arb_bus.gnt_valid[l])
            ptr[l] <= arb_bus.gnt_chan[l];
        end
      end
    end
  end

  // ----------------------------------------
  // Read mux, reserved bits zero
  // ----------------------------------------
  logic [31:0] prio_word;
  always_comb
  begin
    prio_word = '0;
    for (int l = 0; l < DMAGC_LEVELS; l++)
    begin
      prio_word[l*DMAGC_LEVEL_STRIDE + DMAGC_RR_BIT] = rr_on[l];
      prio_word[l*DMAGC_LEVEL_STRIDE +: DMAGC_PTR_W] = ptr[l];
    end
  end

  wire [31:0] rd_word =
    (ADDR == DMAGC_DEBUG_CONTROL) ? (32'({7'h00, run_in_debug_halt}) & 32'(DMAGC_DEBUG_MASK)) :
    (ADDR == DMAGC_QOS_CONTROL) ? (32'(qos) & 32'(DMAGC_QOS_MASK)) :
    (ADDR == DMAGC_SOFTWARE_TRIGGER_CONTROL) ? (32'(channel_soft_trigger) & DMAGC_TRIG_MASK) :
    (ADDR == DMAGC_PRIORITY_CONTROL_ZERO) ? (prio_word & DMAGC_PRIO_MASK) :
    32'h0000_0000;

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RDATA <= '0;
      SOFT_TRIGGER_PULSE <= '0;
      GRANT_VALID <= '0;
      GRANT_CHANNEL <= '0;
      CONTROLLER_HALT <= 1'b0;
      DATA_MASTER_SERVICE_LEVEL <= DMAGC_QOS_RESET[5:4];
      FETCH_MASTER_SERVICE_LEVEL <= DMAGC_QOS_RESET[3:2];
      WRITEBACK_MASTER_SERVICE_LEVEL <= DMAGC_QOS_RESET[1:0];
    end
    else if (CE)
    begin
      RDATA <= RD ? rd_word : '0;
      SOFT_TRIGGER_PULSE <= SOFT_RESET ? '0 : fire;
      GRANT_VALID <= arb_bus.gnt_valid;
      for (int l = 0; l < DMAGC_LEVELS; l++)
        GRANT_CHANNEL[4*l +: 4] <= arb_bus.gnt_chan[l];
      CONTROLLER_HALT <= frozen;
      DATA_MASTER_SERVICE_LEVEL <= qos[5:4];
      FETCH_MASTER_SERVICE_LEVEL <= qos[3:2];
      WRITEBACK_MASTER_SERVICE_LEVEL <= qos[1:0];
    end
  end
endmodule

/* sim/dmagc_checker.sv */
// Port assertions for the DMA global control block
module dmagc_checker
  import dmagc_pkg::*;
(
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic SOFT_RESET,
  input wire logic [DMAGC_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Status inputs and outputs
  input wire logic DEBUG_HALT,
  input wire logic CTRL_ENABLE,
  input wire logic WRITE_PROTECT,
  input wire logic [DMAGC_CHANNELS-1:0] CHANNEL_PENDING_FLAG,
  input wire logic [DMAGC_CHANNELS-1:0] SOFT_TRIGGER_PULSE,
  input wire logic [DMAGC_LEVELS-1:0] GRANT_VALID,
  input wire logic CONTROLLER_HALT,
  input wire logic [1:0] DATA_MASTER_SERVICE_LEVEL,
  input wire logic [1:0] FETCH_MASTER_SERVICE_LEVEL,
  input wire logic [1:0] WRITEBACK_MASTER_SERVICE_LEVEL
);
  // All three service fields side by side
  wire [5:0] svc = {DATA_MASTER_SERVICE_LEVEL, FETCH_MASTER_SERVICE_LEVEL,
    WRITEBACK_MASTER_SERVICE_LEVEL};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Write to the service register attempted, accepted or refused
  sequence qos_wr_s;
    WR && CE && ADDR == DMAGC_QOS_CONTROL;
  endsequence
  rdata_idle_a: assert property (CE && !RD |=> RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  halt_clear_a: assert property ((CE && !DEBUG_HALT) [*4] |-> !CONTROLLER_HALT)
    else $error("halt without debugger halt");
  grant_halt_a: assert property (CONTROLLER_HALT [*2] |-> GRANT_VALID == 4'h0)
    else $error("grant while halted");
  pulse_cause_a: assert property (SOFT_TRIGGER_PULSE != 0 |->
    $past(WR && CE && ADDR == DMAGC_SOFTWARE_TRIGGER_CONTROL))
    else $error("trigger pulse without write");
  pulse_bits_a: assert property (SOFT_TRIGGER_PULSE != 0 |->
    (SOFT_TRIGGER_PULSE & ~$past(WDATA[11:0])) == 12'h000)
    else $error("trigger pulse on unwritten channel");
  pulse_pend_a: assert property ((SOFT_TRIGGER_PULSE & $past(CHANNEL_PENDING_FLAG, 2) &
    $past(CHANNEL_PENDING_FLAG, 3) & $past(CHANNEL_PENDING_FLAG, 4)) == 12'h000)
    else $error("trigger pulse on pending channel");
  qos_load_a: assert property (qos_wr_s ##0 (!CTRL_ENABLE && !WRITE_PROTECT) |->
    ##2 svc == $past(WDATA[5:0], 2))
    else $error("service levels not loaded");
  qos_guard_a: assert property (qos_wr_s ##0 (CTRL_ENABLE || WRITE_PROTECT) |->
    ##2 $stable(svc))
    else $error("service levels changed by refused write");
  qos_reset_a: assert property (SOFT_RESET && CE && !WR |=> ##1 svc == DMAGC_QOS_RESET)
    else $error("service levels not reset");
endmodule
bind dmagc_top dmagc_checker dmagc_checker_i (.CLK(CLK), .RESETN(RESETN), .CE(CE),
  .SOFT_RESET(SOFT_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .DEBUG_HALT(DEBUG_HALT), .CTRL_ENABLE(CTRL_ENABLE), .WRITE_PROTECT(WRITE_PROTECT),
  .CHANNEL_PENDING_FLAG(CHANNEL_PENDING_FLAG), .SOFT_TRIGGER_PULSE(SOFT_TRIGGER_PULSE),
  .GRANT_VALID(GRANT_VALID), .CONTROLLER_HALT(CONTROLLER_HALT),
  .DATA_MASTER_SERVICE_LEVEL(DATA_MASTER_SERVICE_LEVEL),
  .FETCH_MASTER_SERVICE_LEVEL(FETCH_MASTER_SERVICE_LEVEL),
  .WRITEBACK_MASTER_SERVICE_LEVEL(WRITEBACK_MASTER_SERVICE_LEVEL));

/* sim/dmagc_chan_model.sv */
// Far-side channel model: pending flags raised by software triggers
module dmagc_chan_model
  import dmagc_pkg::*;
(
  // Clock, reset, release from the bench
  input wire logic clk,
  input wire logic rstn,
  input wire logic drop,
  input wire logic [DMAGC_CHANNELS-1:0] kick,
  // Trigger in, pending out
  input wire logic [DMAGC_CHANNELS-1:0] pulse,
  output logic [DMAGC_CHANNELS-1:0] pend
);
  // A triggered or kicked channel stays pending until the bench drops it
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      pend <= 12'h000;
    else
      pend <= pulse | kick | (drop ? 12'h000 : pend);
endmodule

/* sim/dmagc_top_tb_top.sv */
// Self-checking testbench for the DMA global control block
module dmagc_top_tb_top
  import dmagc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench signals
  logic clk = 0, rstn = 0, sres = 0, wr = 0, rd = 0, dbg = 0, ena = 0, wp = 0, drop = 0;
  logic ce = 1;
  logic [11:0] kick = 12'h000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [11:0] req = 12'h000, pend, pulse;
  logic [23:0] lvl = 24'h00_0000;
  logic [3:0] gv;
  logic [15:0] gch;
  logic halt;
  logic [1:0] dq, fq, wq;
  int errors = 0, total_checks = 0;
  dmagc_top dmagc_top_i (.CLK(clk), .RESETN(rstn), .CE(ce), .SOFT_RESET(sres),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DEBUG_HALT(dbg),
    .CTRL_ENABLE(ena), .WRITE_PROTECT(wp), .CHANNEL_PENDING_FLAG(pend), .CHAN_REQUEST(req),
    .CHAN_LEVEL(lvl), .SOFT_TRIGGER_PULSE(pulse), .GRANT_VALID(gv), .GRANT_CHANNEL(gch),
    .CONTROLLER_HALT(halt), .DATA_MASTER_SERVICE_LEVEL(dq),
    .FETCH_MASTER_SERVICE_LEVEL(fq), .WRITEBACK_MASTER_SERVICE_LEVEL(wq));
  dmagc_chan_model dmagc_chan_model_i (.clk(clk), .rstn(rstn), .drop(drop), .kick(kick),
    .pulse(pulse), .pend(pend));
  // Clock and watchdog
  initial forever #12.5 clk = ~clk;
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    results();
  end
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bus cycles
  task wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task rst;
    @(posedge clk) rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Scenarios
  task t_regs;
    rdc(8'h0d, 0);
    rdc(8'h0e, 32'h0000_0015);
    rdc(8'h10, 0);
    rdc(8'h14, 0);
    rdc(8'h20, 0);
    chk({dq, fq, wq}, 6'h15);
  endtask
  task t_debug;
    wrt(8'h0d, 32'h0000_0001);
    rdc(8'h0d, 1);
    @(posedge clk) dbg <= 1'b1;
    wait_n(6);
    chk(halt, 0);
    wrt(8'h0d, 0);
    wait_n(6);
    chk(halt, 1);
    wrt(8'h0d, 1);
    @(posedge clk) dbg <= 1'b0;
    sres <= 1'b1;
    @(posedge clk) sres <= 1'b0;
    rdc(8'h0d, 1);
    rst();
    rdc(8'h0d, 0);
  endtask
  task t_qos;
    wrt(8'h0e, 32'h0000_003f);
    rdc(8'h0e, 32'h0000_003f);
    wrt(8'h0e, 32'h0000_0006);
    rdc(8'h0e, 6);
    chk({dq, fq, wq}, 6'h06);
    @(posedge clk) ena <= 1'b1;
    wrt(8'h0e, 0);
    rdc(8'h0e, 6);
    @(posedge clk) {ena, wp} <= 2'b01;
    wrt(8'h0e, 0);
    rdc(8'h0e, 6);
    @(posedge clk) wp <= 1'b0;
    @(posedge clk) sres <= 1'b1;
    @(posedge clk) sres <= 1'b0;
    rdc(8'h0e, 32'h0000_0015);
    chk({dq, fq, wq}, 6'h15);
    @(posedge clk) ce <= 1'b0;
    wrt(8'h0e, 32'h0000_002a);
    @(posedge clk) ce <= 1'b1;
    rdc(8'h0e, 32'h0000_0015);
  endtask
  task t_trig;
    wrt(8'h10, 32'h0000_0fff);
    chk(pulse, 12'hfff);
    wait_n(4);
    wrt(8'h10, 32'h0000_0020);
    chk(pulse, 0);
    rdc(8'h10, 32'h0000_0020);
    @(posedge clk) drop <= 1'b1;
    @(posedge clk) drop <= 1'b0;
    wait_n(4);
    rdc(8'h10, 32'h0000_0020);
    @(posedge clk) kick <= 12'h020;
    @(posedge clk) kick <= 12'h000;
    wait_n(4);
    rdc(8'h10, 32'h0000_0000);
    wrt(8'h10, 0);
    rdc(8'h10, 0);
    @(posedge clk) drop <= 1'b1;
    @(posedge clk) drop <= 1'b0;
    wp <= 1'b1;
    wait_n(4);
    wrt(8'h10, 1);
    chk(pulse, 0);
    @(posedge clk) wp <= 1'b0;
    wrt(8'h10, 4);
    chk(pulse, 12'h004);
  endtask
  task t_prio;
    wrt(8'h14, 32'h8f8f_8f8f);
    rdc(8'h14, 32'h8f8f_8f8f);
    wrt(8'h14, 32'h0500_0005);
    @(posedge clk) req <= 12'h804;
    wait_n(4);
    chk(gch[3:0], 4'hb);
    @(posedge clk) lvl <= 24'hff_ffff;
    wait_n(4);
    chk({gv[3], gch[15:12]}, 5'h1b);
    @(posedge clk) lvl <= 24'h00_0000;
    wrt(8'h14, 0);
    wait_n(4);
    chk(gch[3:0], 4'h2);
    @(posedge clk) req <= 12'h010;
    wrt(8'h14, 32'h0000_0080);
    wait_n(4);
    chk(gch[3:0], 4'h4);
    rdc(8'h14, 32'h0000_0084);
    @(posedge clk) req <= 12'h001;
    wrt(8'h14, 4);
    wait_n(4);
    chk({gv[0], gch[3:0]}, 5'h10);
    rdc(8'h14, 4);
    @(posedge clk) dbg <= 1'b1;
    wait_n(6);
    chk(gv, 4'h0);
    @(posedge clk) dbg <= 1'b0;
    wait_n(6);
    chk(gv, 4'h1);
    @(posedge clk) req <= 12'h000;
  endtask
  // Verdict and end of run
  task results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst();
    t_regs();
    t_debug();
    t_qos();
    t_trig();
    t_prio();
    results();
  end
endmodule
